// [hrs_pkg.sv]
// Constants, register map and carrier types of the hardware return stack
package hrs_pkg;

  // Store geometry
  localparam int HRS_DEPTH    = 16;
  localparam int HRS_ENTRY_W  = 15;
  localparam int HRS_PTR_W    = 5;
  localparam int HRS_IDX_W    = 4;
  localparam int HRS_DATA_W   = 8;
  localparam int HRS_ADDR_W   = 4;
  localparam int HRS_HIGH_W   = HRS_ENTRY_W - HRS_DATA_W;
  localparam int HRS_FLAG_W   = 2;

  // Pointer positions
  localparam logic [HRS_PTR_W-1:0] HRS_PTR_EMPTY = 5'h1F;
  localparam logic [HRS_PTR_W-1:0] HRS_PTR_LAST  = 5'h0F;
  localparam logic [HRS_PTR_W-1:0] HRS_PTR_ONE   = 5'h01;
  localparam logic [HRS_PTR_W-1:0] HRS_PTR_WRAP  = 5'h10;

  // Register offsets
  localparam logic [HRS_ADDR_W-1:0] HRS_OFS_PTR  = 4'h0;
  localparam logic [HRS_ADDR_W-1:0] HRS_OFS_LOW  = 4'h1;
  localparam logic [HRS_ADDR_W-1:0] HRS_OFS_HIGH = 4'h2;
  localparam logic [HRS_ADDR_W-1:0] HRS_OFS_STAT = 4'h3;
  localparam logic [HRS_ADDR_W-1:0] HRS_OFS_MASK = 4'h4;
  localparam logic [HRS_ADDR_W-1:0] HRS_OFS_CFG  = 4'h5;

  // Field positions
  localparam int HRS_BIT_OVF    = 0;
  localparam int HRS_BIT_UNF    = 1;
  localparam int HRS_BIT_CFG_EN = 0;

  // Reset values
  localparam logic [HRS_FLAG_W-1:0]  HRS_FLAGS_RST = 2'h0;
  localparam logic [HRS_FLAG_W-1:0]  HRS_MASK_RST  = 2'h0;
  localparam logic                   HRS_CFG_RST   = 1'h0;
  localparam logic [HRS_ENTRY_W-1:0] HRS_ENTRY_RST = 15'h0000;
  localparam logic [HRS_DATA_W-1:0]  HRS_RDATA_RST = 8'h00;

  // Core sequencer request
  typedef struct packed {
    logic                   push;
    logic                   pop;
    logic [HRS_ENTRY_W-1:0] pc;
  } hrs_core_req_t;

  // Register port request
  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [HRS_ADDR_W-1:0]  addr;
    logic [HRS_DATA_W-1:0]  wdata;
  } hrs_bus_req_t;

endpackage

// [hrs_entry_store.sv]
// Sixteen by fifteen bit flip-flop store of return addresses
`timescale 1ns/1ps
`default_nettype none
module hrs_entry_store
  import hrs_pkg::*;
(
  // Clock and reset
  input  wire logic                   CLOCK,
  input  wire logic                   RST_N,
  // Write port, low and high parts separately enabled
  input  wire logic                   wr_low_en,
  input  wire logic                   wr_high_en,
  input  wire logic [HRS_IDX_W-1:0]   wr_idx,
  input  wire logic [HRS_ENTRY_W-1:0] wr_data,
  // Read port
  input  wire logic [HRS_IDX_W-1:0]   rd_idx,
  output logic      [HRS_ENTRY_W-1:0] rd_data
);

  logic [HRS_ENTRY_W-1:0] entry_ff [HRS_DEPTH];

  // One entry per generate step; store lies outside program and data space
  genvar gi;
  generate
    for (gi = 0; gi < HRS_DEPTH; gi++) begin : g_entry
      logic [HRS_ENTRY_W-1:0] nxt_entry;
      logic                   hit;
      assign hit = (wr_idx == HRS_IDX_W'(gi));

      // Byte lanes merge so a half write keeps the other half
      always_comb begin
        nxt_entry = entry_ff[gi];
        if (hit && wr_low_en) begin
          nxt_entry[HRS_DATA_W-1:0] = wr_data[HRS_DATA_W-1:0];
        end
        if (hit && wr_high_en) begin
          nxt_entry[HRS_ENTRY_W-1:HRS_DATA_W] = wr_data[HRS_ENTRY_W-1:HRS_DATA_W];
        end
      end

      // Entry register
      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          entry_ff[gi] <= HRS_ENTRY_RST;
        end else begin
          entry_ff[gi] <= nxt_entry;
        end
      end
    end
  endgenerate

  // Asynchronous read of the selected entry
  assign rd_data = entry_ff[rd_idx];

endmodule
`default_nettype wire

// [hrs_fault_flags.sv]
// Sticky overflow and underflow flags, interrupt mask and interrupt output
`timescale 1ns/1ps
`default_nettype none
module hrs_fault_flags
  import hrs_pkg::*;
(
  // Clock and resets; flags survive device reset
  input  wire logic                  CLOCK,
  input  wire logic                  RST_N,
  input  wire logic                  POR_N,
  // Events from the pointer logic
  input  wire logic [HRS_FLAG_W-1:0] set_ev,
  // Software access
  input  wire logic                  clr_wr,
  input  wire logic                  mask_wr,
  input  wire logic [HRS_FLAG_W-1:0] wdata,
  // State
  output logic      [HRS_FLAG_W-1:0] flags,
  output logic      [HRS_FLAG_W-1:0] mask,
  output logic                       irq
);

  logic [HRS_FLAG_W-1:0] flags_ff;
  logic [HRS_FLAG_W-1:0] mask_ff;
  logic [HRS_FLAG_W-1:0] nxt_flags;
  logic [HRS_FLAG_W-1:0] nxt_mask;

  // Set beats a write-one clear in the same cycle so no event is lost
  genvar gb;
  generate
    for (gb = 0; gb < HRS_FLAG_W; gb++) begin : g_flag
      always_comb begin
        nxt_flags[gb] = flags_ff[gb];
        if (clr_wr && wdata[gb]) begin
          nxt_flags[gb] = 1'b0;
        end
        if (set_ev[gb]) begin
          nxt_flags[gb] = 1'b1;
        end
      end
    end
  endgenerate

  // Mask next value
  always_comb begin
    nxt_mask = mask_wr ? wdata : mask_ff;
  end

  // Flags reset only at power-on, keeping the fault cause visible
  always_ff @(posedge CLOCK) begin
    if (!POR_N) begin
      flags_ff <= HRS_FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Mask register
  always_ff @(posedge CLOCK) begin
    if (!RST_N || !POR_N) begin
      mask_ff <= HRS_MASK_RST;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  assign flags = flags_ff;
  assign mask  = mask_ff;
  assign irq   = |(flags_ff & mask_ff);

  // An unmasked fault raises the interrupt the edge after it
  irq_level_a: assert property (@(posedge CLOCK) disable iff (!POR_N || !RST_N)
    (|(set_ev & nxt_mask)) |=> irq)
    else $error("interrupt missing after unmasked fault");

  flag_sticky_a: assert property (@(posedge CLOCK) disable iff (!POR_N)
    (set_ev[HRS_BIT_OVF] && clr_wr) |=> flags_ff[HRS_BIT_OVF])
    else $error("overflow set lost to clear");

endmodule
`default_nettype wire

// [hrs_top.sv]
// Hardware return-address stack: pointer, top-entry window, fault logic
// Functional notes
// - Sixteen entries of fifteen bits, separate from program and data space.
// - Call, call through working register and interrupt branch push the PC.
// - Return, return with literal and return from interrupt pop the stack.
// - Push and pop never modify the PC upper latch.
// - With fault reset disabled the store wraps; push seventeen overwrites push one.
// - Overflow and underflow flags set on faults whether or not reset enabled.
// - Stack pointer is five bits so faults differ from valid positions.
// - Top entry high and low are read/write, together the addressed entry.
// - Software sets the pointer, then the top pair reaches that entry.
// - Calls and interrupts increment the pointer, returns decrement it.
// - Pointer names the used entry; push increments first, pop reads first.
// - Software may read the pointer at any time.
// - With fault reset enabled a fault resets the device and sets its flag.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module hrs_top
  import hrs_pkg::*;
(
  // Clock and resets
  input  wire logic                   CLOCK,
  input  wire logic                   RST_N,
  input  wire logic                   POR_N,
  // Core sequencer
  input  wire hrs_core_req_t          CORE_REQ,
  output logic      [HRS_ENTRY_W-1:0] POP_PC,
  output logic                        DEVICE_RESET_REQ,
  // Register port
  input  wire hrs_bus_req_t           BUS_REQ,
  output logic      [HRS_DATA_W-1:0]  RDATA,
  // Interrupt
  output logic                        IRQ
);

  // Pointer, configuration and output registers
  logic [HRS_PTR_W-1:0]   ptr_ff;
  logic [HRS_PTR_W-1:0]   nxt_ptr;
  logic                   cfg_en_ff;
  logic                   nxt_cfg_en;
  logic [HRS_ENTRY_W-1:0] pop_pc_ff;
  logic [HRS_ENTRY_W-1:0] nxt_pop_pc;
  logic                   rst_req_ff;
  logic                   nxt_rst_req;
  logic [HRS_DATA_W-1:0]  rdata_ff;
  logic [HRS_DATA_W-1:0]  nxt_rdata;

  // Decoded requests
  logic                   push;
  logic                   pop;
  logic                   ovf_ev;
  logic                   unf_ev;
  logic                   sw_ptr_wr;
  logic                   sw_low_wr;
  logic                   sw_high_wr;
  logic                   stat_wr;
  logic                   mask_wr;
  logic                   cfg_wr;

  // Store ports
  logic                   st_wr_low;
  logic                   st_wr_high;
  logic [HRS_IDX_W-1:0]   st_wr_idx;
  logic [HRS_ENTRY_W-1:0] st_wr_data;
  logic [HRS_ENTRY_W-1:0] top_entry;
  logic [HRS_PTR_W-1:0]   push_ptr;

  // Flag block
  logic [HRS_FLAG_W-1:0]  flags;
  logic [HRS_FLAG_W-1:0]  mask;
  logic [HRS_FLAG_W-1:0]  set_ev;

  // Push wins over a pop in the same cycle; the sequencer never asks both
  assign push = CORE_REQ.push;
  assign pop  = CORE_REQ.pop && !CORE_REQ.push;

  // Beyond sixteenth level on push, beyond first level on pop
  assign ovf_ev = push && (ptr_ff != HRS_PTR_EMPTY) && (ptr_ff >= HRS_PTR_LAST);
  assign unf_ev = pop && (ptr_ff == HRS_PTR_EMPTY);

  // Register decode; core traffic takes the store and pointer first
  assign sw_ptr_wr  = BUS_REQ.wr && (BUS_REQ.addr == HRS_OFS_PTR) && !push && !pop;
  assign sw_low_wr  = BUS_REQ.wr && (BUS_REQ.addr == HRS_OFS_LOW) && !push;
  assign sw_high_wr = BUS_REQ.wr && (BUS_REQ.addr == HRS_OFS_HIGH) && !push;
  assign stat_wr    = BUS_REQ.wr && (BUS_REQ.addr == HRS_OFS_STAT);
  assign mask_wr    = BUS_REQ.wr && (BUS_REQ.addr == HRS_OFS_MASK);
  assign cfg_wr     = BUS_REQ.wr && (BUS_REQ.addr == HRS_OFS_CFG);

  // Position after a push; past the last level the index wraps to entry zero
  always_comb begin
    if (ptr_ff == HRS_PTR_EMPTY) begin
      push_ptr = '0;
    end else if (ptr_ff >= HRS_PTR_LAST) begin
      push_ptr = {1'b1, ptr_ff[HRS_IDX_W-1:0] + HRS_IDX_W'(1)};
    end else begin
      push_ptr = ptr_ff + HRS_PTR_ONE;
    end
  end

  // Store write: a push writes the PC at the incremented position
  always_comb begin
    st_wr_low  = 1'b0;
    st_wr_high = 1'b0;
    st_wr_idx  = ptr_ff[HRS_IDX_W-1:0];
    st_wr_data = {BUS_REQ.wdata[HRS_HIGH_W-1:0], BUS_REQ.wdata};
    if (push) begin
      st_wr_low  = 1'b1;
      st_wr_high = 1'b1;
      st_wr_idx  = push_ptr[HRS_IDX_W-1:0];
      st_wr_data = CORE_REQ.pc;
    end else begin
      st_wr_low  = sw_low_wr;
      st_wr_high = sw_high_wr;
    end
  end

  hrs_entry_store u_store (
    .CLOCK      (CLOCK),
    .RST_N      (RST_N),
    .wr_low_en  (st_wr_low),
    .wr_high_en (st_wr_high),
    .wr_idx     (st_wr_idx),
    .wr_data    (st_wr_data),
    .rd_idx     (ptr_ff[HRS_IDX_W-1:0]),
    .rd_data    (top_entry)
  );

  // Pointer next value; a fault under reset enable empties the stack
  always_comb begin
    nxt_ptr = ptr_ff;
    if ((ovf_ev || unf_ev) && cfg_en_ff) begin
      nxt_ptr = HRS_PTR_EMPTY;
    end else if (push) begin
      nxt_ptr = push_ptr;
    end else if (pop && !unf_ev) begin
      nxt_ptr = ptr_ff - HRS_PTR_ONE;
    end else if (sw_ptr_wr) begin
      nxt_ptr = BUS_REQ.wdata[HRS_PTR_W-1:0];
    end
  end

  // Pointer starts empty so the first push lands in entry zero
  always_ff @(posedge CLOCK) begin
    if (!RST_N || !POR_N) begin
      ptr_ff <= HRS_PTR_EMPTY;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  // Pop reads the top entry before the pointer moves; an underflow
  // still returns whatever sits at the empty index
  always_comb begin
    nxt_pop_pc = pop ? top_entry : pop_pc_ff;
  end

  // Fault reset request, one cycle wide
  always_comb begin
    nxt_rst_req = (ovf_ev || unf_ev) && cfg_en_ff;
  end

  // Configuration of fault behaviour
  always_comb begin
    nxt_cfg_en = cfg_wr ? BUS_REQ.wdata[HRS_BIT_CFG_EN] : cfg_en_ff;
  end

  // Read data mux, valid only in the cycle after the read strobe
  always_comb begin
    nxt_rdata = HRS_RDATA_RST;
    if (BUS_REQ.rd) begin
      case (BUS_REQ.addr)
        HRS_OFS_PTR:  nxt_rdata = HRS_DATA_W'(ptr_ff);
        HRS_OFS_LOW:  nxt_rdata = top_entry[HRS_DATA_W-1:0];
        HRS_OFS_HIGH: nxt_rdata = HRS_DATA_W'(top_entry[HRS_ENTRY_W-1:HRS_DATA_W]);
        HRS_OFS_STAT: nxt_rdata = HRS_DATA_W'(flags);
        HRS_OFS_MASK: nxt_rdata = HRS_DATA_W'(mask);
        HRS_OFS_CFG:  nxt_rdata = HRS_DATA_W'(cfg_en_ff);
        default:      nxt_rdata = HRS_RDATA_RST;
      endcase
    end
  end

  // Output and configuration registers
  always_ff @(posedge CLOCK) begin
    if (!RST_N || !POR_N) begin
      pop_pc_ff  <= HRS_ENTRY_RST;
      rst_req_ff <= 1'b0;
      cfg_en_ff  <= HRS_CFG_RST;
      rdata_ff   <= HRS_RDATA_RST;
    end else begin
      pop_pc_ff  <= nxt_pop_pc;
      rst_req_ff <= nxt_rst_req;
      cfg_en_ff  <= nxt_cfg_en;
      rdata_ff   <= nxt_rdata;
    end
  end

  // Only the return address leaves; there is no path to the upper latch
  assign POP_PC           = pop_pc_ff;
  assign DEVICE_RESET_REQ = rst_req_ff;
  assign RDATA            = rdata_ff;

  // Flags set on faults in both modes
  always_comb begin
    set_ev              = '0;
    set_ev[HRS_BIT_OVF] = ovf_ev;
    set_ev[HRS_BIT_UNF] = unf_ev;
  end

  hrs_fault_flags u_flags (
    .CLOCK   (CLOCK),
    .RST_N   (RST_N),
    .POR_N   (POR_N),
    .set_ev  (set_ev),
    .clr_wr  (stat_wr),
    .mask_wr (mask_wr),
    .wdata   (BUS_REQ.wdata[HRS_FLAG_W-1:0]),
    .flags   (flags),
    .mask    (mask),
    .irq     (IRQ)
  );

  // Checks
  // A second fault inside the pulse cycle legitimately stretches it
  sequence s_fault_pulse;
    (DEVICE_RESET_REQ && ptr_ff == HRS_PTR_EMPTY) ##1
    (!DEVICE_RESET_REQ || $past(nxt_rst_req));
  endsequence

  sequence s_wrap_write(logic [HRS_ENTRY_W-1:0] pc);
    (ptr_ff == HRS_PTR_WRAP) && (top_entry == pc);
  endsequence

  push_incr_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    (push && ptr_ff < HRS_PTR_LAST) |=> ptr_ff == $past(ptr_ff) + HRS_PTR_ONE)
    else $error("push did not advance pointer");

  pop_decr_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    (pop && ptr_ff != HRS_PTR_EMPTY && !cfg_en_ff) |=> ptr_ff == $past(ptr_ff) - HRS_PTR_ONE)
    else $error("pop did not retreat pointer");

  push_store_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    (push && !ovf_ev) |=> top_entry == $past(CORE_REQ.pc))
    else $error("pushed pc not at new top");

  pop_value_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    pop |=> POP_PC == $past(top_entry))
    else $error("pop returned wrong address");

  wrap_over_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    (push && ptr_ff == HRS_PTR_LAST && !cfg_en_ff) |=> s_wrap_write($past(CORE_REQ.pc)))
    else $error("seventeenth push did not overwrite entry zero");

  ovf_flag_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    (push && ptr_ff == HRS_PTR_LAST) |=> flags[HRS_BIT_OVF])
    else $error("overflow flag not set");

  unf_flag_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    (pop && ptr_ff == HRS_PTR_EMPTY) |=> flags[HRS_BIT_UNF])
    else $error("underflow flag not set");

  fault_reset_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    ((ovf_ev || unf_ev) && cfg_en_ff) |=> s_fault_pulse)
    else $error("fault reset missing or not one cycle");

  no_fault_rst_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    !cfg_en_ff |=> !DEVICE_RESET_REQ)
    else $error("reset requested with fault reset disabled");

  ptr_read_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    (BUS_REQ.rd && BUS_REQ.addr == HRS_OFS_PTR) |=> RDATA == HRS_DATA_W'($past(ptr_ff)))
    else $error("pointer read wrong");

  reset_empty_a: assert property (@(posedge CLOCK) disable iff (!POR_N)
    !RST_N |=> ptr_ff == HRS_PTR_EMPTY)
    else $error("pointer not empty after reset");

  // Register window and output holding checks
  ptr_write_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    (BUS_REQ.wr && BUS_REQ.addr == HRS_OFS_PTR && !CORE_REQ.push && !CORE_REQ.pop) |=>
    ptr_ff == $past(BUS_REQ.wdata[HRS_PTR_W-1:0]))
    else $error("pointer write not taken");

  unf_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    (pop && ptr_ff == HRS_PTR_EMPTY) |=> ptr_ff == HRS_PTR_EMPTY)
    else $error("underflow moved the pointer");

  pop_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    !pop |=> $stable(POP_PC))
    else $error("return address changed without a pop");

  rdata_idle_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    !BUS_REQ.rd |=> RDATA == HRS_RDATA_RST)
    else $error("read data not cleared after its cycle");

  high_read_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    (BUS_REQ.rd && BUS_REQ.addr == HRS_OFS_HIGH) |=>
    RDATA == HRS_DATA_W'($past(top_entry[HRS_ENTRY_W-1:HRS_DATA_W])))
    else $error("top high read wrong");

  low_read_a: assert property (@(posedge CLOCK) disable iff (!RST_N || !POR_N)
    (BUS_REQ.rd && BUS_REQ.addr == HRS_OFS_LOW) |=>
    RDATA == $past(top_entry[HRS_DATA_W-1:0]))
    else $error("top low read wrong");

endmodule
`default_nettype wire

// [hrs_core_model.sv]
// Core sequencer model issuing push and pop requests to the return stack
`timescale 1ns/1ps
`default_nettype none
module hrs_core_model
  import hrs_pkg::*;
(
  // Clock
  input  wire logic    CLOCK,
  // Request to the stack
  output hrs_core_req_t CORE_REQ
);
  // Idle until the bench asks; pc is zeroed between requests
  initial CORE_REQ = '0;

  // Call or interrupt branch: one-cycle push with the PC beside it
  task automatic push(input logic [HRS_ENTRY_W-1:0] pc);
    @(posedge CLOCK);
    CORE_REQ <= '{push: 1'b1, pop: 1'b0, pc: pc};
    @(posedge CLOCK);
    CORE_REQ <= '0;
  endtask

  // Return of any kind: one-cycle pop, no PC carried
  task automatic pop();
    @(posedge CLOCK);
    CORE_REQ <= '{push: 1'b0, pop: 1'b1, pc: '0};
    @(posedge CLOCK);
    CORE_REQ <= '0;
  endtask
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench of the hardware return stack
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb
  import hrs_pkg::*;
;
  logic                   clock;
  logic                   rst_n;
  logic                   por_n;
  hrs_core_req_t          core_req;
  hrs_bus_req_t           bus;
  logic [HRS_ENTRY_W-1:0] pop_pc;
  logic                   dev_rst;
  logic [HRS_DATA_W-1:0]  rdata;
  logic                   irq;
  int                     errors;
  int                     n_checks;
  int                     n_pulses;

  // Clock at 100 MHz
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  hrs_core_model core (.CLOCK(clock), .CORE_REQ(core_req));

  hrs_top uut (
    .CLOCK(clock), .RST_N(rst_n), .POR_N(por_n), .CORE_REQ(core_req),
    .POP_PC(pop_pc), .DEVICE_RESET_REQ(dev_rst), .BUS_REQ(bus),
    .RDATA(rdata), .IRQ(irq)
  );

  // Counts fault reset pulses; each must last one cycle
  always @(posedge clock) begin
    if (dev_rst === 1'b1) n_pulses++;
  end

  // Register write: one strobe cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus <= '0;
  endtask

  // Register read; data stand only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus <= '0;
    #1;
    `CHK(rdata, e)
  endtask

  task automatic popchk(input logic [HRS_ENTRY_W-1:0] e);
    core.pop();
    #1;
    `CHK(pop_pc, e)
  endtask

  task automatic ichk(input logic e);
    #1;
    `CHK(irq, e)
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog well beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    bus = '0;
    errors = 0;
    n_checks = 0;
    n_pulses = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    // Reset values and the unmapped space
    rchk(HRS_OFS_PTR, 8'h1F);
    rchk(HRS_OFS_STAT, 8'h00);
    rchk(HRS_OFS_MASK, 8'h00);
    rchk(HRS_OFS_CFG, 8'h00);
    wr(4'h9, 8'hFF);
    for (int a = 6; a < 16; a++) rchk(a[3:0], 8'h00);
    $display("test reset done");
    // Plain push and pop, pointer visible throughout
    core.push(15'h1234);
    core.push(15'h0ABC);
    rchk(HRS_OFS_PTR, 8'h01);
    rchk(HRS_OFS_LOW, 8'hBC);
    rchk(HRS_OFS_HIGH, 8'h0A);
    popchk(15'h0ABC);
    rchk(HRS_OFS_PTR, 8'h00);
    popchk(15'h1234);
    rchk(HRS_OFS_PTR, 8'h1F);
    $display("test push pop done");
    // Software rewrites an inner entry; no push runs meanwhile
    for (int i = 0; i < 3; i++) core.push(15'h0A00 + 15'(i));
    wr(HRS_OFS_PTR, 8'h00);
    wr(HRS_OFS_LOW, 8'h55);
    wr(HRS_OFS_HIGH, 8'h2A);
    rchk(HRS_OFS_HIGH, 8'h2A);
    wr(HRS_OFS_PTR, 8'h01);
    rchk(HRS_OFS_LOW, 8'h01);
    wr(HRS_OFS_HIGH, 8'hFF);
    rchk(HRS_OFS_HIGH, 8'h7F);
    popchk(15'h7F01);
    popchk(15'h2A55);
    $display("test window done");
    // Seventeen pushes with fault reset off wrap onto the first entry
    for (int i = 0; i < 17; i++) core.push(15'h0100 + 15'(i));
    rchk(HRS_OFS_PTR, 8'h10);
    rchk(HRS_OFS_STAT, 8'h01);
    ichk(1'b0);
    wr(HRS_OFS_MASK, 8'h03);
    ichk(1'b1);
    wr(HRS_OFS_STAT, 8'h01);
    ichk(1'b0);
    rchk(HRS_OFS_STAT, 8'h00);
    wr(HRS_OFS_PTR, 8'h00);
    rchk(HRS_OFS_LOW, 8'h10);
    rchk(HRS_OFS_HIGH, 8'h01);
    wr(HRS_OFS_PTR, 8'h01);
    rchk(HRS_OFS_LOW, 8'h01);
    `CHK(n_pulses, 0)
    $display("test wrap done");
    // Pop past empty, then a device reset keeps the flag
    wr(HRS_OFS_PTR, 8'h1F);
    core.pop();
    rchk(HRS_OFS_PTR, 8'h1F);
    rchk(HRS_OFS_STAT, 8'h02);
    ichk(1'b1);
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    ichk(1'b0);
    rchk(HRS_OFS_STAT, 8'h02);
    rchk(HRS_OFS_MASK, 8'h00);
    $display("test underflow done");
    // Fault reset on: overflow and underflow each pulse the reset request
    wr(HRS_OFS_CFG, 8'h01);
    wr(HRS_OFS_PTR, 8'h0F);
    core.push(15'h7FFF);
    repeat (3) @(posedge clock);
    `CHK(n_pulses, 1)
    rchk(HRS_OFS_PTR, 8'h1F);
    rchk(HRS_OFS_STAT, 8'h03);
    core.pop();
    repeat (3) @(posedge clock);
    `CHK(n_pulses, 2)
    rchk(HRS_OFS_PTR, 8'h1F);
    $display("test fault reset done");
    conclude();
  end
endmodule
`default_nettype wire
